// file: ibe_byte_engine.sv
// Master byte engine for the two-wire bus with register port and arbitration.
// What this block does
// - Buffer write in transmit sets buffer_full, starts counter; clears after eight bits.
// - Each bit driven after SCL falls, SCL low one period, high one period.
// - Falling edge of eighth clock clears buffer_full and releases SDA.
// - Ninth clock falling edge samples SDA into peer_ack_result, low means acknowledged.
// - After ninth clock set event flag, hold SCL low, wait for next write.
// - Buffer write during any active sequence is dropped and sets write_collision.
// - Receive enable starts reception only when idle, otherwise ignored.
// - In reception each rollover toggles SCL and SDA bits shift in.
// - After eighth received clock, store byte, set flags, clear enable, hold SCL low.
// - In reception buffer_full sets on byte store and clears on a buffer read made while idle.
// - Byte completed while buffer_full still set raises receive_overflow.
// - Acknowledge sequence drives level, low one period, high one period, then idle.
// - Stop drives SDA low, waits period, releases SCL, one period later SDA.
// - SDA high with SCL high sets halt_detected; period later finish stop, set event.
// - Reset disables the port and abandons any transfer.
// - Start and stop detected flags clear on reset or disable.
// - Released one read back low while SCL high sets collision flag, go idle.
// - Collision in a byte stops it, clears buffer_full, releases lines.
// - Collision in acknowledge or stop aborts it and clears its enable bits.
// - After losing arbitration, a bus stop condition sets the event flag.
// - After collision the next write sends its byte from the first bit.
// - In sleep reception continues and events wake the processor if enabled.
// - Counter reloads from low seven bits and counts to zero, one period each.
// - While SCL is released the counter pauses until SCL reads high.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
module ibe_byte_engine #(
  parameter int AW = ibe_pkg::IBE_AW,
  parameter int DW = ibe_pkg::IBE_DW
) (
  // Clock and reset.
  input  wire logic          i_clock,
  input  wire logic          i_rstn,
  // Register port.
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [DW-1:0] o_rdata,
  // Processor sleep and wake.
  input  wire logic          i_sleep,
  input  wire logic          i_event_irq_en,
  output logic               o_wake,
  // Open-drain bus lines.
  input  wire logic          i_scl,
  output logic               o_scl,
  output logic               o_scl_oe,
  input  wire logic          i_sda,
  output logic               o_sda,
  output logic               o_sda_oe
);
  import ibe_pkg::*;

  typedef struct packed {
    ibe_state_t  state;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_d;
    logic        sda_s1;
    logic        sda_s2;
    logic        sda_d;
    logic        scl_oe;
    logic        sda_oe;
    logic [7:0]  buffer;
    logic [7:0]  shift;
    logic [3:0]  bitcnt;
    logic [6:0]  reload;
    logic        enable;
    logic        bf;
    logic        ack_en;
    logic        rx_en;
    logic        halt_en;
    logic        ack_lvl;
    logic        peer_ack;
    logic        begin_det;
    logic        halt_det;
    logic        pe;
    logic        coll;
    logic        ovf;
    logic        write_collision;
    logic        lost;
    logic        wake;
    logic [7:0]  rdata;
  } ibe_regs_t;

  ibe_regs_t r;
  ibe_regs_t next_r;
  logic      brg_reload;
  logic      brg_run;
  logic      brg_done;
  logic      lose;
  logic      wr_buf;
  logic      wr_ctrl2;
  logic      bus_start;
  logic      bus_stop;

  // Register address match.
  function automatic logic hit(input logic [AW-1:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction

  ibe_rate_counter #(
    .RW (IBE_RW)
  ) u_rate (
    .i_clock  (i_clock),
    .i_rstn   (i_rstn),
    .i_reload (brg_reload),
    .i_run    (brg_run),
    .i_value  (r.reload),
    .o_done   (brg_done)
  );

  // The bus lines only ever pull low; the level pins stay at zero.
  assign o_scl    = 1'b0;
  assign o_sda    = 1'b0;
  assign o_scl_oe = r.scl_oe;
  assign o_sda_oe = r.sda_oe;
  assign o_rdata  = r.rdata;
  assign o_wake   = r.wake;

  // Decoded strobes and bus conditions seen on the synchronised lines.
  assign wr_buf    = i_wr && hit(i_addr, IBE_OFF_BUF);
  assign wr_ctrl2  = i_wr && hit(i_addr, IBE_OFF_CTRL2);
  assign bus_start = r.scl_s2 && r.scl_d && r.sda_d && !r.sda_s2;
  assign bus_stop  = r.scl_s2 && r.scl_d && !r.sda_d && r.sda_s2;

  // Next-state logic; register-write clears are applied first so a later set wins; arbitration loss and disable are applied last.
  always_comb begin
    next_r = r;
    brg_reload = 1'b0;
    brg_run = 1'b1;
    lose = 1'b0;
    next_r.scl_s1 = i_scl;
    next_r.scl_s2 = r.scl_s1;
    next_r.scl_d  = r.scl_s2;
    next_r.sda_s1 = i_sda;
    next_r.sda_s2 = r.sda_s1;
    next_r.sda_d  = r.sda_s2;
    next_r.rdata  = 8'h00;

    // Reads answer one cycle later; unmapped words read zero.
    if (i_rd) begin
      if (hit(i_addr, IBE_OFF_BUF)) begin
        next_r.rdata = r.buffer;
        if (r.state == IBE_IDLE) begin
          next_r.bf = 1'b0;
        end
      end
      if (hit(i_addr, IBE_OFF_CTRL2)) begin
        next_r.rdata[IBE_C2_HALT] = r.halt_en;
        next_r.rdata[IBE_C2_RX]   = r.rx_en;
        next_r.rdata[IBE_C2_ACK]  = r.ack_en;
        next_r.rdata[IBE_C2_ALVL] = r.ack_lvl;
        next_r.rdata[IBE_C2_PACK] = r.peer_ack;
      end
      if (hit(i_addr, IBE_OFF_STATUS)) begin
        next_r.rdata[IBE_ST_BF]    = r.bf;
        next_r.rdata[IBE_ST_BEGIN] = r.begin_det;
        next_r.rdata[IBE_ST_HALT]  = r.halt_det;
      end
      if (hit(i_addr, IBE_OFF_FLAGS)) begin
        next_r.rdata[IBE_FL_PE]   = r.pe;
        next_r.rdata[IBE_FL_COLL] = r.coll;
        next_r.rdata[IBE_FL_OVF]  = r.ovf;
        next_r.rdata[IBE_FL_WRITE_COLLISION] = r.write_collision;
      end
      if (hit(i_addr, IBE_OFF_RELOAD)) begin
        next_r.rdata = {1'b0, r.reload};
      end
      if (hit(i_addr, IBE_OFF_CTRL1)) begin
        next_r.rdata[IBE_C1_EN] = r.enable;
      end
    end

    // Sticky flags clear only by software, writing a one to the bit.
    if (i_wr && hit(i_addr, IBE_OFF_FLAGS)) begin
      if (i_wdata[IBE_FL_PE]) next_r.pe = 1'b0;
      if (i_wdata[IBE_FL_COLL]) next_r.coll = 1'b0;
      if (i_wdata[IBE_FL_OVF]) next_r.ovf = 1'b0;
      if (i_wdata[IBE_FL_WRITE_COLLISION]) next_r.write_collision = 1'b0;
    end
    if (i_wr && hit(i_addr, IBE_OFF_RELOAD)) begin
      next_r.reload = i_wdata[6:0];
    end
    if (i_wr && hit(i_addr, IBE_OFF_CTRL1)) begin
      next_r.enable = i_wdata[IBE_C1_EN];
    end
    if (wr_ctrl2) begin
      next_r.ack_lvl = i_wdata[IBE_C2_ALVL];
    end

    // Bus monitor keeps running after arbitration is lost.
    if (bus_start) begin
      next_r.begin_det = 1'b1;
      next_r.halt_det  = 1'b0;
    end
    if (bus_stop) begin
      next_r.halt_det  = 1'b1;
      next_r.begin_det = 1'b0;
      if (r.lost) begin
        next_r.pe   = 1'b1;
        next_r.lost = 1'b0;
      end
    end

    // A buffer write outside idle never reaches the buffer.
    if (wr_buf && r.state != IBE_IDLE) begin
      next_r.write_collision = 1'b1;
    end

    case (r.state)
      IBE_IDLE: begin
        if (wr_buf && r.enable) begin
          next_r.buffer = i_wdata;
          next_r.shift  = i_wdata;
          next_r.bitcnt = 4'h0;
          next_r.bf     = 1'b1;
          next_r.scl_oe = 1'b1;
          next_r.sda_oe = !i_wdata[7];
          next_r.state  = IBE_TX_LOW;
          brg_reload    = 1'b1;
        end else if (wr_ctrl2 && r.enable) begin
          // Only one sequence may start; anything else stays idle.
          if (i_wdata[IBE_C2_ACK]) begin
            next_r.ack_en = 1'b1;
            next_r.scl_oe = 1'b1;
            next_r.sda_oe = !i_wdata[IBE_C2_ALVL];
            next_r.state  = IBE_ACK_LOW;
            brg_reload    = 1'b1;
          end else if (i_wdata[IBE_C2_RX]) begin
            next_r.rx_en  = 1'b1;
            next_r.scl_oe = 1'b1;
            next_r.sda_oe = 1'b0;
            next_r.bitcnt = 4'h0;
            next_r.state  = IBE_RX_LOW;
            brg_reload    = 1'b1;
          end else if (i_wdata[IBE_C2_HALT]) begin
            next_r.halt_en = 1'b1;
            next_r.sda_oe  = 1'b1;
            next_r.state   = IBE_STOP_SDA;
          end
        end
      end
      IBE_TX_LOW: begin
        if (brg_done) begin
          next_r.scl_oe = 1'b0;
          next_r.state  = IBE_TX_HIGH;
          brg_reload    = 1'b1;
        end
      end
      IBE_TX_HIGH: begin
        brg_run = r.scl_s2;
        if (!r.sda_oe && r.scl_s2 && !r.sda_s2 && r.bitcnt < IBE_ACK_BIT) begin
          lose = 1'b1;
        end else if (brg_done) begin
          next_r.scl_oe = 1'b1;
          if (r.bitcnt == IBE_ACK_BIT) begin
            next_r.peer_ack = r.sda_s2;
            next_r.pe       = 1'b1;
            next_r.state    = IBE_IDLE;
          end else begin
            next_r.bitcnt = r.bitcnt + 4'h1;
            next_r.shift  = {r.shift[6:0], 1'b0};
            if (r.bitcnt == IBE_LAST_BIT) begin
              next_r.bf     = 1'b0;
              next_r.sda_oe = 1'b0;
            end else begin
              next_r.sda_oe = !r.shift[6];
            end
            next_r.state = IBE_TX_LOW;
            brg_reload   = 1'b1;
          end
        end
      end
      IBE_RX_LOW: begin
        if (brg_done) begin
          next_r.scl_oe = 1'b0;
          next_r.state  = IBE_RX_HIGH;
          brg_reload    = 1'b1;
        end
      end
      IBE_RX_HIGH: begin
        brg_run = r.scl_s2;
        if (brg_done) begin
          next_r.scl_oe = 1'b1;
          next_r.shift  = {r.shift[6:0], r.sda_s2};
          next_r.bitcnt = r.bitcnt + 4'h1;
          if (r.bitcnt == IBE_LAST_BIT) begin
            next_r.rx_en  = 1'b0;
            next_r.buffer = {r.shift[6:0], r.sda_s2};
            next_r.bf     = 1'b1;
            next_r.pe     = 1'b1;
            if (r.bf) begin
              next_r.ovf = 1'b1;
            end
            next_r.state = IBE_IDLE;
          end else begin
            next_r.state = IBE_RX_LOW;
            brg_reload   = 1'b1;
          end
        end
      end
      IBE_ACK_LOW: begin
        if (brg_done) begin
          next_r.scl_oe = 1'b0;
          next_r.state  = IBE_ACK_HIGH;
          brg_reload    = 1'b1;
        end
      end
      IBE_ACK_HIGH: begin
        brg_run = r.scl_s2;
        if (!r.sda_oe && r.scl_s2 && !r.sda_s2) begin
          lose = 1'b1;
        end else if (brg_done) begin
          next_r.scl_oe = 1'b1;
          next_r.ack_en = 1'b0;
          next_r.state  = IBE_IDLE;
        end
      end
      IBE_STOP_SDA: begin
        if (!r.sda_s2) begin
          next_r.state = IBE_STOP_LOW;
          brg_reload   = 1'b1;
        end
      end
      IBE_STOP_LOW: begin
        if (brg_done) begin
          next_r.scl_oe = 1'b0;
          next_r.state  = IBE_STOP_HIGH;
          brg_reload    = 1'b1;
        end
      end
      IBE_STOP_HIGH: begin
        brg_run = r.scl_s2;
        if (brg_done) begin
          next_r.sda_oe = 1'b0;
          next_r.state  = IBE_STOP_REL;
        end
      end
      IBE_STOP_REL: begin
        // A line that stays low here is held by another party; wait for it.
        if (r.scl_s2 && r.sda_s2) begin
          next_r.halt_det = 1'b1;
          next_r.state    = IBE_STOP_DONE;
          brg_reload      = 1'b1;
        end
      end
      IBE_STOP_DONE: begin
        if (!r.sda_s2) begin
          lose = 1'b1;
        end else if (brg_done) begin
          next_r.halt_en = 1'b0;
          next_r.pe      = 1'b1;
          next_r.state   = IBE_IDLE;
        end
      end
      default: begin
        next_r.state = IBE_IDLE;
      end
    endcase

    // Arbitration loss frees the bus and leaves the buffer writable.
    if (lose) begin
      next_r.coll    = 1'b1;
      next_r.lost    = 1'b1;
      next_r.bf      = 1'b0;
      next_r.scl_oe  = 1'b0;
      next_r.sda_oe  = 1'b0;
      next_r.ack_en  = 1'b0;
      next_r.rx_en   = 1'b0;
      next_r.halt_en = 1'b0;
      next_r.state   = IBE_IDLE;
    end

    // A disabled port drops any sequence, releases both lines and forgets the bus state.
    if (!r.enable) begin
      next_r.state     = IBE_IDLE;
      next_r.scl_oe    = 1'b0;
      next_r.sda_oe    = 1'b0;
      next_r.ack_en    = 1'b0;
      next_r.rx_en     = 1'b0;
      next_r.halt_en   = 1'b0;
      next_r.lost      = 1'b0;
      next_r.begin_det = 1'b0;
      next_r.halt_det  = 1'b0;
    end

    // Sleep does not gate the engine, so reception still completes.
    next_r.wake = i_sleep && i_event_irq_en && next_r.pe;
  end

  // State register; reset leaves the port disabled and the bus released.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      r        <= '0;
      r.state  <= IBE_IDLE;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_d  <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_d  <= 1'b1;
      r.buffer <= IBE_RST_BUF;
      r.reload <= IBE_RST_RELOAD;
    end else begin
      r <= next_r;
    end
  end
endmodule

// file: ibe_pkg.sv
// Package with register map, field positions and reset values of the two-wire byte engine.
package ibe_pkg;
  // Register word indices on the plain register port.
  localparam logic [2:0] IBE_OFF_BUF    = 3'h0;
  localparam logic [2:0] IBE_OFF_CTRL2  = 3'h1;
  localparam logic [2:0] IBE_OFF_STATUS = 3'h2;
  localparam logic [2:0] IBE_OFF_FLAGS  = 3'h3;
  localparam logic [2:0] IBE_OFF_RELOAD = 3'h4;
  localparam logic [2:0] IBE_OFF_CTRL1  = 3'h5;
  localparam int IBE_AW = 3;
  localparam int IBE_DW = 8;
  localparam int IBE_RW = 7;

  // Field positions in control_two_reg.
  localparam int IBE_C2_HALT = 2;
  localparam int IBE_C2_RX   = 3;
  localparam int IBE_C2_ACK  = 4;
  localparam int IBE_C2_ALVL = 5;
  localparam int IBE_C2_PACK = 6;
  // Field positions in port_status_reg.
  localparam int IBE_ST_BF    = 0;
  localparam int IBE_ST_BEGIN = 3;
  localparam int IBE_ST_HALT  = 4;
  // Field positions in the sticky flag register.
  localparam int IBE_FL_PE   = 0;
  localparam int IBE_FL_COLL = 1;
  localparam int IBE_FL_OVF  = 2;
  localparam int IBE_FL_WRITE_COLLISION = 3;
  // Field position of the module enable in the first control register.
  localparam int IBE_C1_EN = 5;

  // Reset values and the last data and acknowledge bit counts.
  localparam logic [7:0] IBE_RST_BUF    = 8'h00;
  localparam logic [6:0] IBE_RST_RELOAD = 7'h00;
  localparam logic [3:0] IBE_LAST_BIT   = 4'h7;
  localparam logic [3:0] IBE_ACK_BIT    = 4'h8;

  // Engine sequencer states.
  typedef enum logic [3:0] {
    IBE_IDLE, IBE_TX_LOW, IBE_TX_HIGH, IBE_RX_LOW, IBE_RX_HIGH,
    IBE_ACK_LOW, IBE_ACK_HIGH, IBE_STOP_SDA, IBE_STOP_LOW,
    IBE_STOP_HIGH, IBE_STOP_REL, IBE_STOP_DONE
  } ibe_state_t;
endpackage

// file: ibe_rate_counter.sv
// Reload down-counter that paces every half bit of the two-wire bus.
`timescale 1ns/1ps
module ibe_rate_counter #(
  parameter int RW = ibe_pkg::IBE_RW
) (
  // Clock and reset.
  input  wire logic          i_clock,
  input  wire logic          i_rstn,
  // Control from the sequencer.
  input  wire logic          i_reload,
  input  wire logic          i_run,
  input  wire logic [RW-1:0] i_value,
  // Rollover strobe.
  output logic               o_done
);
  import ibe_pkg::*;

  typedef struct packed {
    logic [RW-1:0] count;
    logic          active;
  } ibe_rc_t;

  ibe_rc_t r;
  ibe_rc_t next_r;

  // Rollover fires when the count has run out; a stalled run holds it back.
  assign o_done = r.active && i_run && (r.count == '0);

  // Reload wins over counting so a fresh half bit always starts full length.
  always_comb begin
    next_r = r;
    if (i_reload) begin
      next_r.count  = i_value;
      next_r.active = 1'b1;
    end else if (r.active && i_run) begin
      if (r.count == '0) begin
        next_r.active = 1'b0;
      end else begin
        next_r.count = r.count - 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// file: ibe_byte_engine_asserts.sv
// Port-level timing and reset checks for the two-wire byte engine.
`timescale 1ns/1ps
module ibe_byte_engine_asserts #(
  parameter int AW = ibe_pkg::IBE_AW,
  parameter int DW = ibe_pkg::IBE_DW
) (
  // Clock and reset.
  input  wire logic          i_clock,
  input  wire logic          i_rstn,
  // Register port.
  input  wire logic [AW-1:0] i_addr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  input  wire logic [DW-1:0] o_rdata,
  // Sleep and wake.
  input  wire logic          i_sleep,
  input  wire logic          i_event_irq_en,
  input  wire logic          o_wake,
  // Bus lines.
  input  wire logic          i_scl,
  input  wire logic          o_scl,
  input  wire logic          o_scl_oe,
  input  wire logic          i_sda,
  input  wire logic          o_sda,
  input  wire logic          o_sda_oe
);
  import ibe_pkg::*;
  logic [6:0] rl;
  logic [7:0] low_cnt;
  logic [7:0] high_cnt;
  logic [1:0] wr_q;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  // Shadow the reload value and time both SCL phases; counts saturate so long holds stay legal.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rl       <= IBE_RST_RELOAD;
      low_cnt  <= 8'h00;
      high_cnt <= 8'hff;
      wr_q     <= 2'h0;
    end else begin
      if (i_wr && i_addr == IBE_OFF_RELOAD) begin
        rl <= i_wdata[6:0];
      end
      wr_q     <= {wr_q[0], i_wr};
      low_cnt  <= !o_scl_oe ? 8'h00 : (low_cnt == 8'hff ? low_cnt : low_cnt + 8'h01);
      high_cnt <= (o_scl_oe || !i_scl) ? 8'h00 : (high_cnt == 8'hff ? high_cnt : high_cnt + 8'h01);
    end
  end

  // A write just before a line change may be a disable, which drops both lines at once.
  oe_after_reset_a: assert property ($rose(i_rstn) |-> !o_scl_oe && !o_sda_oe)
    else $error("bus line pulled low right after reset");
  disable_release_a: assert property (i_wr && i_addr == IBE_OFF_CTRL1 && !i_wdata[IBE_C1_EN]
    |=> ##[0:2] (!o_scl_oe && !o_sda_oe))
    else $error("lines still pulled after module disable");
  wake_gate_a: assert property (o_wake |-> $past(i_sleep) && $past(i_event_irq_en))
    else $error("wake raised without sleep and interrupt enable");
  rdata_window_a: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside the read answer cycle");
  scl_release_a: assert property ($fell(o_scl_oe) && wr_q == 2'h0 |-> $stable(o_sda_oe))
    else $error("data line moved together with clock release");
  scl_low_min_a: assert property ($fell(o_scl_oe) && wr_q == 2'h0 |-> low_cnt > {1'b0, rl})
    else $error("clock low phase shorter than one rate period");
  scl_high_min_a: assert property ($rose(o_scl_oe) |-> high_cnt > {1'b0, rl})
    else $error("clock high phase shorter than one rate period");
  stop_release_a: assert property ($fell(o_sda_oe) && !o_scl_oe && wr_q == 2'h0
    |-> high_cnt > {1'b0, rl})
    else $error("data released too soon after clock release");
endmodule

bind ibe_byte_engine ibe_byte_engine_asserts #(.AW(AW), .DW(DW)) u_asserts (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep), .i_event_irq_en(i_event_irq_en),
  .o_wake(o_wake), .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sda(i_sda),
  .o_sda(o_sda), .o_sda_oe(o_sda_oe));

// file: ibe_slave_model.sv
// Behavioural slave: takes or returns one byte, acknowledges, stretches and can fight for SDA.
`timescale 1ns/1ps
module ibe_slave_model (
  // Clock and bus wires.
  input  wire logic       i_clock,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  // Scenario controls.
  input  wire logic       i_restart,
  input  wire logic       i_rx_mode,
  input  wire logic       i_nack,
  input  wire logic [7:0] i_byte,
  input  wire logic [3:0] i_stretch,
  input  wire logic       i_collide,
  // Pull-downs and the byte taken in.
  output logic            o_scl_oe,
  output logic            o_sda_oe,
  output logic [7:0]      o_got
);
  logic       scl_q = 1'b1;
  logic [3:0] bit_n = 4'h0;
  logic [3:0] hold = 4'h0;
  logic       scl_pd = 1'b0;
  logic       sda_pd = 1'b0;
  logic [7:0] got = 8'h00;

  assign o_scl_oe = scl_pd;
  assign o_sda_oe = sda_pd;
  assign o_got    = got;

  // Bits are counted on rising SCL, so the first fall out of an idle bus moves no data.
  always @(posedge i_clock) begin
    scl_q <= i_scl;
    if (i_restart) begin
      bit_n  <= 4'h0;
      sda_pd <= i_rx_mode ? ~i_byte[7] : i_collide;
    end else if (scl_q && !i_scl) begin
      scl_pd <= i_stretch != 4'h0;
      hold   <= i_stretch;
      if (bit_n == 4'h8) begin
        sda_pd <= ~i_rx_mode & ~i_nack;
      end else if (bit_n != 4'h0) begin
        sda_pd <= i_rx_mode & (bit_n < 4'h8) & ~i_byte[3'h7 - bit_n[2:0]];
      end
    end else if (!scl_q && i_scl) begin
      bit_n <= bit_n + 4'h1;
      if (bit_n < 4'h8 && !i_rx_mode) begin
        got <= {got[6:0], i_sda};
      end
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
      if (hold == 4'h1) begin
        scl_pd <= 1'b0;
      end
    end
  end
endmodule

// file: ibe_byte_engine_tb_top.sv
// Self-checking bench for the two-wire byte engine against a behavioural slave.
`timescale 1ns/1ps
module ibe_byte_engine_tb_top;
  import ibe_pkg::*;
  logic       i_clock = 1'b0;
  logic       i_rstn = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_sleep = 1'b0;
  logic       irq_en = 1'b0;
  logic [7:0] o_rdata;
  logic       o_wake, o_scl, o_scl_oe, o_sda, o_sda_oe, s_scl_oe, s_sda_oe;
  logic       restart = 1'b0;
  logic       rx_mode = 1'b0;
  logic       nack = 1'b0;
  logic       collide = 1'b0;
  logic [7:0] s_byte = 8'h00;
  logic [3:0] stretch = 4'h0;
  logic [7:0] got, d, b;
  int         errors = 0;
  int         checked = 0;
  int         seed = 96166;
  // Both wires have pull-ups; any party pulling low wins.
  wire        scl_w = ~(o_scl_oe | s_scl_oe);
  wire        sda_w = ~(o_sda_oe | s_sda_oe);

  always #5 i_clock = ~i_clock;

  ibe_byte_engine uut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep), .i_event_irq_en(irq_en),
    .o_wake(o_wake), .i_scl(scl_w), .o_scl(o_scl), .o_scl_oe(o_scl_oe), .i_sda(sda_w),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe));
  ibe_slave_model u_slave (
    .i_clock(i_clock), .i_scl(scl_w), .i_sda(sda_w), .i_restart(restart),
    .i_rx_mode(rx_mode), .i_nack(nack), .i_byte(s_byte), .i_stretch(stretch),
    .i_collide(collide), .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe), .o_got(got));

  // Comparison, register cycles and slave set-up shared by every scenario.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic wait_bit(input logic [2:0] a, input int p, input logic v);
    logic [7:0] q;
    int n = 0;
    q = {8{~v}};
    while (q[p] !== v && n < 4000) begin
      rd(a, q);
      n++;
    end
    if (q[p] !== v) begin
      errors++;
      $display("unexpected timeout on register %0d bit %0d", a, p);
    end
  endtask
  task automatic arm(input logic rx, input logic no_ack, input logic col, input logic [7:0] v);
    @(posedge i_clock);
    rx_mode <= rx;
    nack    <= no_ack;
    collide <= col;
    s_byte  <= v;
    restart <= 1'b1;
    @(posedge i_clock);
    restart <= 1'b0;
  endtask
  function automatic logic [7:0] bitv(input int p);
    return 8'h01 << p;
  endfunction

  task automatic final_report;
    $display("checks %0d, errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog sized well above the expected run of about a thousand cycles.
  initial begin
    #900000;
    errors++;
    final_report();
  end

  // Main sequence: reset map, transmit, collision, reception in sleep, stop.
  initial begin
    repeat (6) @(posedge i_clock);
    i_rstn <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      check("reset value", d, 8'h00);
    end
    check("line drivers", {4'h0, o_scl, o_sda, o_scl_oe, o_sda_oe}, 8'h00);
    wr(IBE_OFF_CTRL1, 8'h00);
    wr(IBE_OFF_RELOAD, 8'h03);
    wr(IBE_OFF_CTRL1, bitv(IBE_C1_EN));
    for (int k = 0; k < 2; k++) begin
      b = 8'($random(seed));
      stretch <= (k == 1) ? 4'hf : 4'h0;
      arm(1'b0, k == 1, 1'b0, 8'h00);
      wr(IBE_OFF_BUF, b);
      rd(IBE_OFF_STATUS, d);
      check("full in transmit", d & bitv(IBE_ST_BF), bitv(IBE_ST_BF));
      wr(IBE_OFF_BUF, ~b);
      wr(IBE_OFF_CTRL2, bitv(IBE_C2_RX));
      rd(IBE_OFF_CTRL2, d);
      check("receive refused", d & bitv(IBE_C2_RX), 8'h00);
      wait_bit(IBE_OFF_FLAGS, IBE_FL_PE, 1'b1);
      check("slave byte", got, b);
      rd(IBE_OFF_CTRL2, d);
      check("ack status", d, (k == 1) ? bitv(IBE_C2_PACK) : 8'h00);
      rd(IBE_OFF_STATUS, d);
      check("full after byte", d & bitv(IBE_ST_BF), 8'h00);
      rd(IBE_OFF_FLAGS, d);
      check("flags after byte", d, bitv(IBE_FL_PE) | bitv(IBE_FL_WRITE_COLLISION));
      wr(IBE_OFF_FLAGS, 8'hff);
      rd(IBE_OFF_FLAGS, d);
      check("flags cleared", d, 8'h00);
    end
    stretch <= 4'h0;
    b = 8'($random(seed)) | 8'h80;
    arm(1'b0, 1'b0, 1'b1, 8'h00);
    wr(IBE_OFF_BUF, b);
    wait_bit(IBE_OFF_FLAGS, IBE_FL_COLL, 1'b1);
    rd(IBE_OFF_FLAGS, d);
    check("collision flags", d, bitv(IBE_FL_COLL));
    rd(IBE_OFF_STATUS, d);
    check("full after collision", d & bitv(IBE_ST_BF), 8'h00);
    arm(1'b0, 1'b0, 1'b0, 8'h00);
    wait_bit(IBE_OFF_FLAGS, IBE_FL_PE, 1'b1);
    rd(IBE_OFF_FLAGS, d);
    check("bus stop seen", d, bitv(IBE_FL_PE) | bitv(IBE_FL_COLL));
    wr(IBE_OFF_FLAGS, 8'hff);
    wr(IBE_OFF_BUF, b);
    wait_bit(IBE_OFF_FLAGS, IBE_FL_PE, 1'b1);
    check("byte after collision", got, b);
    wr(IBE_OFF_FLAGS, 8'hff);
    i_sleep <= 1'b1;
    irq_en  <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      b = 8'($random(seed));
      arm(1'b1, 1'b0, 1'b0, b);
      wr(IBE_OFF_CTRL2, bitv(IBE_C2_RX));
      wait_bit(IBE_OFF_FLAGS, IBE_FL_PE, 1'b1);
      rd(IBE_OFF_FLAGS, d);
      check("receive flags", d, (i == 2) ? 8'h05 : 8'h01);
      check("wake", {7'h00, o_wake}, 8'h01);
      rd(IBE_OFF_CTRL2, d);
      check("receive enable done", d, 8'h00);
      if (i == 0) begin
        rd(IBE_OFF_STATUS, d);
        check("full after receive", d & bitv(IBE_ST_BF), bitv(IBE_ST_BF));
        rd(IBE_OFF_BUF, d);
        check("received byte", d, b);
        rd(IBE_OFF_STATUS, d);
        check("full after read", d & bitv(IBE_ST_BF), 8'h00);
        wr(IBE_OFF_CTRL2, bitv(IBE_C2_ACK));
        wait_bit(IBE_OFF_CTRL2, IBE_C2_ACK, 1'b0);
        check("ack level driven", {7'h00, o_sda_oe}, 8'h01);
      end
      wr(IBE_OFF_FLAGS, 8'hff);
      rd(IBE_OFF_FLAGS, d);
      check("wake dropped", {7'h00, o_wake}, 8'h00);
    end
    wr(IBE_OFF_CTRL2, bitv(IBE_C2_HALT));
    wait_bit(IBE_OFF_FLAGS, IBE_FL_PE, 1'b1);
    rd(IBE_OFF_STATUS, d);
    check("stop detected", d & bitv(IBE_ST_HALT), bitv(IBE_ST_HALT));
    rd(IBE_OFF_CTRL2, d);
    check("stop enable done", d & bitv(IBE_C2_HALT), 8'h00);
    final_report();
  end
endmodule
